// ---- qic_chain.sv ----
// module: interpolating filter chain, half-band stages and cic
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - two consecutive input samples, i then q, form one pair.
// - first half-band stage, 47 taps per channel, doubles the rate.
// - second half-band stage, 15 taps, doubles the rate again.
// - optional third half-band stage, 11 taps, bypassed unless selected or quarter-word.
// - half-band ratio is eight with the third stage, else four.
// - half-band coefficients are symmetric, giving linear phase.
// - half-band stages keep near unity gain, negligible insertion loss.
// - cic interpolator runs combs at the low rate before integrators.
// - cic emits R outputs per input, R from 2 to 63.
// - cic order four, one unit delay per comb.
// - cic scaling is exactly unity for power-of-two R without gain boost.
// - gain boost bit doubles the cic output.
// - quarter-word input always runs with the third stage engaged.
// - cic overflow is sticky and only reset clears it.
module qic_chain (
   input  wire logic                        I_SYS_CLK,
   input  wire logic                        I_RST,
   input  wire logic [qic_pkg::QIC_DW-1:0]  I_SAMPLE,
   input  wire logic                        I_SAMPLE_VALID,
   input  wire logic                        I_THIRD_SEL,
   input  wire logic                        I_QUARTER_FMT,
   input  wire logic                        I_GAIN_BOOST,
   input  wire logic [qic_pkg::QIC_RW-1:0]  I_CIC_RATE,
   output qic_pkg::qic_pair_t               O_PAIR,
   output logic                             O_PAIR_VALID,
   output logic                             O_PAIR_TAKEN,
   output logic                             O_CIC_OVERFLOW
);
   import qic_pkg::*;

   localparam logic signed [QIC_CIC_W-1:0] HI =
      QIC_CIC_W'((2 ** (QIC_DW - 1)) - 1);
   localparam logic signed [QIC_CIC_W-1:0] LO = -HI - QIC_CIC_W'(1);

   // ----------------------------------------------------------------
   // configuration
   // ----------------------------------------------------------------
   logic                     third_eff;
   logic                     boost_q;
   logic [QIC_RW-1:0]        rate_q;
   logic [QIC_SHIFT_W-1:0]   cic_shift;

   // quarter-word data is too slow for four-fold, so force the stage
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         third_eff <= 1'b0;
         boost_q   <= 1'b0;
      end else begin
         third_eff <= I_THIRD_SEL | I_QUARTER_FMT;
         boost_q   <= I_GAIN_BOOST;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         rate_q <= QIC_RATE_MIN;
      end else if (I_CIC_RATE < QIC_RATE_MIN) begin
         rate_q <= QIC_RATE_MIN;
      end else begin
         rate_q <= I_CIC_RATE;
      end
   end

   // smallest s with 2**s >= R**3, so dc gain R**3 / 2**s
   function automatic logic [QIC_SHIFT_W-1:0] cube_shift(
      input logic [QIC_RW-1:0] r);
      logic [QIC_CUBE_W-1:0]  cube;
      logic [QIC_SHIFT_W-1:0] s;
      cube = QIC_CUBE_W'(r) * QIC_CUBE_W'(r) * QIC_CUBE_W'(r);
      s    = '0;
      for (int b = 0; b < QIC_CUBE_W; b++) begin
         if ((QIC_CUBE_W'(1) << b) < cube) begin
            s = QIC_SHIFT_W'(b + 1);
         end
      end
      return s;
   endfunction

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         cic_shift <= '0;
      end else if (boost_q) begin
         cic_shift <= cube_shift(rate_q) - QIC_SHIFT_W'(1);
      end else begin
         cic_shift <= cube_shift(rate_q);
      end
   end

   // ----------------------------------------------------------------
   // pair assembly
   // ----------------------------------------------------------------
   logic                     word_phase;
   logic signed [QIC_DW-1:0] held_i;
   qic_pair_t                pending_pair;
   logic                     pending_full;
   logic                     head_take;
   qic_pair_t                head_pair;

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         word_phase <= 1'b0;
         held_i     <= '0;
      end else if (I_SAMPLE_VALID) begin
         word_phase <= ~word_phase;
         if (!word_phase) begin
            held_i <= I_SAMPLE;
         end
      end
   end

   // a pair landing in the cycle it is taken survives the clear
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         pending_pair <= '0;
         pending_full <= 1'b0;
      end else if (I_SAMPLE_VALID && word_phase) begin
         pending_pair.i <= held_i;
         pending_pair.q <= I_SAMPLE;
         pending_full   <= 1'b1;
      end else if (head_take) begin
         pending_full <= 1'b0;
      end
   end

   // starved chain is fed zeros rather than stale data
   assign head_pair = pending_full ? pending_pair : '0;

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         O_PAIR_TAKEN <= 1'b0;
      end else begin
         O_PAIR_TAKEN <= head_take & pending_full;
      end
   end

   // ----------------------------------------------------------------
   // half-band stages, pulled from the cic end
   // ----------------------------------------------------------------
   logic      cic_take;
   logic      hb1_take;
   logic      hb2_take;
   logic      hb3_take;
   logic      hb3_up_take;
   qic_pair_t hb1_pair;
   qic_pair_t hb2_pair;
   qic_pair_t hb3_pair;
   qic_pair_t cic_in;

   assign hb3_take = third_eff & cic_take;
   assign hb2_take = third_eff ? hb3_up_take : cic_take;
   assign cic_in   = third_eff ? hb3_pair : hb2_pair;

   qic_halfband #(
      .TAPS (QIC_HB1_TAPS),
      .COEF (QIC_HB1_COEF)
   ) u_hb1 (
      .i_clk     (I_SYS_CLK),
      .i_rst     (I_RST),
      .i_up_pair (head_pair),
      .i_take    (hb1_take),
      .o_up_take (head_take),
      .o_pair    (hb1_pair)
   );

   qic_halfband #(
      .TAPS (QIC_HB2_TAPS),
      .COEF (QIC_HB2_COEF)
   ) u_hb2 (
      .i_clk     (I_SYS_CLK),
      .i_rst     (I_RST),
      .i_up_pair (hb1_pair),
      .i_take    (hb2_take),
      .o_up_take (hb1_take),
      .o_pair    (hb2_pair)
   );

   qic_halfband #(
      .TAPS (QIC_HB3_TAPS),
      .COEF (QIC_HB3_COEF)
   ) u_hb3 (
      .i_clk     (I_SYS_CLK),
      .i_rst     (I_RST),
      .i_up_pair (hb2_pair),
      .i_take    (hb3_take),
      .o_up_take (hb3_up_take),
      .o_pair    (hb3_pair)
   );

   // ----------------------------------------------------------------
   // cic rate counter: one low-rate sample every R clocks
   // ----------------------------------------------------------------
   logic [QIC_RW-1:0] rate_cnt;

   assign cic_take = (rate_cnt == '0);

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         rate_cnt <= '0;
      end else if (cic_take) begin
         rate_cnt <= rate_q - QIC_RATE_ONE;
      end else begin
         rate_cnt <= rate_cnt - QIC_RATE_ONE;
      end
   end

   // ----------------------------------------------------------------
   // cic: combs at the low rate, zero stuffing, integrators
   // ----------------------------------------------------------------
   logic signed [QIC_CIC_W-1:0] cdly  [2][QIC_CIC_N];
   logic signed [QIC_CIC_W-1:0] cval  [2][QIC_CIC_N+1];
   logic signed [QIC_CIC_W-1:0] stuff [2];
   logic signed [QIC_CIC_W-1:0] integ [2][QIC_CIC_N];
   logic signed [QIC_CIC_W-1:0] scaled [2];

   always_comb begin
      cval[0][0] = QIC_CIC_W'(cic_in.i);
      cval[1][0] = QIC_CIC_W'(cic_in.q);
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < QIC_CIC_N; k++) begin
            cval[c][k+1] = cval[c][k] - cdly[c][k];
         end
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         for (int c = 0; c < 2; c++) begin
            stuff[c] <= '0;
            for (int k = 0; k < QIC_CIC_N; k++) begin
               cdly[c][k] <= '0;
            end
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            stuff[c] <= cic_take ? cval[c][QIC_CIC_N] : '0;
            if (cic_take) begin
               for (int k = 0; k < QIC_CIC_N; k++) begin
                  cdly[c][k] <= cval[c][k];
               end
            end
         end
      end
   end

   // wrapping sums cancel exactly, so overflow inside is harmless
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < QIC_CIC_N; k++) begin
               integ[c][k] <= '0;
            end
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            integ[c][0] <= integ[c][0] + stuff[c];
            for (int k = 1; k < QIC_CIC_N; k++) begin
               integ[c][k] <= integ[c][k] + integ[c][k-1];
            end
         end
      end
   end

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         scaled[c] = integ[c][QIC_CIC_N-1] >>> cic_shift;
      end
   end

   // ----------------------------------------------------------------
   // output register and sticky overflow
   // ----------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         O_PAIR       <= '0;
         O_PAIR_VALID <= 1'b0;
      end else begin
         O_PAIR_VALID <= 1'b1;
         O_PAIR.i <= scaled[0][QIC_DW-1:0];
         O_PAIR.q <= scaled[1][QIC_DW-1:0];
      end
   end

   // flag set when either scaled output leaves the 12-bit range, held until reset
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         O_CIC_OVERFLOW <= 1'b0;
      end else if (scaled[0] > HI || scaled[0] < LO ||
                   scaled[1] > HI || scaled[1] < LO) begin
         O_CIC_OVERFLOW <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_pair_assembled;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      I_SAMPLE_VALID && word_phase |=>
         pending_full && pending_pair.q == $past(I_SAMPLE);
   endproperty
   a_pair_assembled: assert property (p_pair_assembled)
      else $error("second sample did not complete a pair");

   property p_quarter_third;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      I_QUARTER_FMT |=> third_eff;
   endproperty
   a_quarter_third: assert property (p_quarter_third)
      else $error("quarter-word input without third stage");

   property p_bypass_idle;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      !third_eff |-> !hb3_take && hb2_take == cic_take;
   endproperty
   a_bypass_idle: assert property (p_bypass_idle)
      else $error("third stage pulled while bypassed");

   property p_hb_ratio;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      head_take |-> hb1_take && hb2_take && cic_take &&
         (third_eff == hb3_take);
   endproperty
   a_hb_ratio: assert property (p_hb_ratio)
      else $error("half-band take chain broken");

   property p_cic_spacing;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      cic_take |=> !cic_take ##0 rate_cnt == $past(rate_q) - QIC_RATE_ONE;
   endproperty
   a_cic_spacing: assert property (p_cic_spacing)
      else $error("cic input spacing not R clocks");

   property p_unity_pow2;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      (rate_q & (rate_q - QIC_RATE_ONE)) == '0 && !boost_q |=>
         (QIC_CUBE_W'(1) << cic_shift) == QIC_CUBE_W'($past(rate_q)) *
         QIC_CUBE_W'($past(rate_q)) * QIC_CUBE_W'($past(rate_q));
   endproperty
   a_unity_pow2: assert property (p_unity_pow2)
      else $error("cic scaling not unity at a power-of-two rate");

   property p_boost_shift;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      $rose(boost_q) && $stable(rate_q) |=>
         cic_shift == $past(cic_shift) - QIC_SHIFT_W'(1);
   endproperty
   a_boost_shift: assert property (p_boost_shift)
      else $error("gain boost did not double the cic output");

   property p_stuff_zero;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      !cic_take |=> stuff[0] == '0 && stuff[1] == '0;
   endproperty
   a_stuff_zero: assert property (p_stuff_zero)
      else $error("nonzero sample between cic inputs");

   property p_overflow_sticky;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      O_CIC_OVERFLOW |=> O_CIC_OVERFLOW [*3];
   endproperty
   a_overflow_sticky: assert property (p_overflow_sticky)
      else $error("overflow flag cleared without reset");

   property p_valid_steady;
      @(posedge I_SYS_CLK) disable iff (I_RST)
      O_PAIR_VALID |=> O_PAIR_VALID;
   endproperty
   a_valid_steady: assert property (p_valid_steady)
      else $error("output strobe dropped");

endmodule

`default_nettype wire

// ---- qic_halfband.sv ----
// module: one polyphase half-band interpolate-by-two stage for i and q
`timescale 1ns/1ps
`default_nettype none

module qic_halfband #(
   parameter int TAPS = qic_pkg::QIC_HB3_TAPS,
   parameter logic signed [qic_pkg::QIC_CW-1:0] COEF [(TAPS+1)/4] =
      qic_pkg::QIC_HB3_COEF
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire qic_pkg::qic_pair_t i_up_pair,
   input  wire logic              i_take,
   output logic                   o_up_take,
   output qic_pkg::qic_pair_t     o_pair
);
   import qic_pkg::*;

   localparam int K  = (TAPS + 1) / 2;
   localparam int U  = K / 2;
   localparam int AW = QIC_DW + QIC_CW + 6;
   localparam logic signed [AW-1:0] HI = AW'((2 ** (QIC_DW - 1)) - 1);
   localparam logic signed [AW-1:0] LO = -HI - AW'(1);

   logic signed [QIC_DW-1:0] li [K];
   logic signed [QIC_DW-1:0] lq [K];
   logic                     phase;

   // ----------------------------------------------------------------
   // odd phase: symmetric pairs share one multiply
   // ----------------------------------------------------------------
   function automatic logic signed [QIC_DW-1:0] fir(
      input logic signed [QIC_DW-1:0] x [K]);
      logic signed [AW-1:0]     acc;
      logic signed [QIC_DW:0]   s;
      acc = '0;
      for (int j = 0; j < U; j++) begin
         s   = (QIC_DW+1)'(x[j]) + (QIC_DW+1)'(x[K-1-j]);
         acc = acc + AW'(s) * AW'(COEF[j]);
      end
      acc = acc >>> QIC_CFRAC;
      if (acc > HI) begin
         acc = HI;
      end else if (acc < LO) begin
         acc = LO;
      end
      return acc[QIC_DW-1:0];
   endfunction

   // upstream pulled once per two local outputs
   assign o_up_take = i_take & phase;

   // ----------------------------------------------------------------
   // phase and delay line
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         phase <= 1'b0;
      end else if (i_take) begin
         phase <= ~phase;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int k = 0; k < K; k++) begin
            li[k] <= '0;
            lq[k] <= '0;
         end
      end else if (o_up_take) begin
         li[0] <= i_up_pair.i;
         lq[0] <= i_up_pair.q;
         for (int k = 1; k < K; k++) begin
            li[k] <= li[k-1];
            lq[k] <= lq[k-1];
         end
      end
   end

   // even phase is the centre sample, odd phase the interpolated one
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pair <= '0;
      end else if (i_take) begin
         if (phase) begin
            o_pair.i <= li[U-1];
            o_pair.q <= lq[U-1];
         end else begin
            o_pair.i <= fir(li);
            o_pair.q <= fir(lq);
         end
      end
   end

   property p_hb_even_follows;
      @(posedge i_clk) disable iff (i_rst)
      i_take && phase |=> !phase ##0 o_pair.i == $past(li[U-1]);
   endproperty
   a_hb_even_follows: assert property (p_hb_even_follows)
      else $error("half-band even phase not the centre sample");

endmodule

`default_nettype wire

// ---- qic_pkg.sv ----
// package: types and constants for the quadrature interpolation chain
package qic_pkg;

   // ----------------------------------------------------------------
   // data path widths
   // ----------------------------------------------------------------
   localparam int QIC_DW      = 12;
   localparam int QIC_CW      = 16;
   localparam int QIC_CFRAC   = 15;
   localparam int QIC_CIC_N   = 4;
   localparam int QIC_CIC_W   = 32;
   localparam int QIC_RW      = 6;
   localparam int QIC_CUBE_W  = 18;
   localparam int QIC_SHIFT_W = 5;

   // ----------------------------------------------------------------
   // comb integrator rate limits
   // ----------------------------------------------------------------
   localparam logic [QIC_RW-1:0] QIC_RATE_MIN = 6'h02;
   localparam logic [QIC_RW-1:0] QIC_RATE_ONE = 6'h01;

   // ----------------------------------------------------------------
   // half-band stages: unique odd-phase taps, outermost first
   // each set sums to half of unity so both phases pass dc at gain one
   // ----------------------------------------------------------------
   localparam int QIC_HB1_TAPS = 47;
   localparam int QIC_HB2_TAPS = 15;
   localparam int QIC_HB3_TAPS = 11;

   localparam logic signed [QIC_CW-1:0] QIC_HB1_COEF [12] = '{
      -16'sh0014, 16'sh001E, -16'sh0032, 16'sh0050,
      -16'sh0078, 16'sh00AA, -16'sh00FA, 16'sh0168,
      -16'sh0208, 16'sh030C, -16'sh0514, 16'sh4348};
   localparam logic signed [QIC_CW-1:0] QIC_HB2_COEF [4] = '{
      -16'sh0096, 16'sh0384, -16'sh0AF0, 16'sh4802};
   localparam logic signed [QIC_CW-1:0] QIC_HB3_COEF [3] = '{
      16'sh0190, -16'sh0A28, 16'sh4898};

   // ----------------------------------------------------------------
   // carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic signed [QIC_DW-1:0] i;
      logic signed [QIC_DW-1:0] q;
   } qic_pair_t;

endpackage

// ---- qic_source.sv ----
// partner model: baseband source sending one i/q pair per pull
`timescale 1ns/1ps
`default_nettype none

module qic_source (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_en,
   input  wire logic                  i_halve,
   input  wire logic                  i_taken,
   input  wire qic_pkg::qic_pair_t    i_pair,
   output logic [qic_pkg::QIC_DW-1:0] o_sample,
   output logic                       o_valid
);
   import qic_pkg::*;

   logic                     need;
   logic                     q_next;
   logic signed [QIC_DW-1:0] i_word;
   logic signed [QIC_DW-1:0] q_word;

   // ------
   // scaling
   // ------
   // halved under boost so the comb_integrator_gain_boost stays at or below one
   assign i_word = i_halve ? (i_pair.i >>> 1) : i_pair.i; // halved i
   assign q_word = i_halve ? (i_pair.q >>> 1) : i_pair.q; // halved q

   // ------
   // pacing
   // ------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         need     <= 1'b1;
         q_next   <= 1'b0;
         o_valid  <= 1'b0;
         o_sample <= 12'h000;
      end else if (q_next) begin
         o_sample <= q_word;
         q_next   <= 1'b0;
      end else if (i_en && (need || i_taken)) begin
         // constant pair sits deep in the flat band
         o_sample <= i_word;
         o_valid  <= 1'b1;
         q_next   <= 1'b1;
         need     <= 1'b0;
      end else begin
         o_valid  <= 1'b0;
         // released line toggles between the last word and its inverse
         o_sample <= ~o_sample;
         if (i_taken) begin
            need <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ---- testbench.sv ----
// testbench: row table of dc cases, reset and overflow tests
`timescale 1ns/1ps
`default_nettype none

`define QIC_CHECK(nm, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("unexpected %s expected %h seen %h", nm, exp, got); \
      end \
   end

module testbench;
   import qic_pkg::*;

   typedef struct packed {
      logic [QIC_RW-1:0] rate;
      logic              third;
      logic              quart;
      logic              boost;
      qic_pair_t         stim;
      qic_pair_t         want;
   } qic_row_t;

   // ------
   // cases: rate, third, quarter, boost, stimulus, steady output
   // ------
   localparam qic_row_t ROWS [9] = '{
      '{6'h02,1'b0,1'b0,1'b0,'{12'h200,12'h100},'{12'h200,12'h100}},
      '{6'h04,1'b0,1'b1,1'b0,'{12'h300,12'h180},'{12'h300,12'h180}},
      '{6'h03,1'b0,1'b0,1'b0,'{12'h040,12'h020},'{12'h036,12'h01B}},
      '{6'h03,1'b1,1'b0,1'b1,'{12'h040,12'h020},'{12'h036,12'h01B}},
      '{6'h05,1'b0,1'b0,1'b1,'{12'h100,12'h080},'{12'h0FA,12'h07D}},
      '{6'h06,1'b0,1'b0,1'b0,'{12'h100,12'h080},'{12'h0D8,12'h06C}},
      '{6'h07,1'b1,1'b0,1'b0,'{12'h200,12'h100},'{12'h157,12'h0AB}},
      '{6'h01,1'b0,1'b0,1'b0,'{12'h100,12'h080},'{12'h100,12'h080}},
      '{6'h3F,1'b0,1'b0,1'b0,'{12'h400,12'h200},'{12'h3D0,12'h1E8}}};

   logic              clk;
   logic              rst;
   logic              src_en;
   logic              halve;
   logic              third;
   logic              quart;
   logic              boost;
   logic [QIC_RW-1:0] rate;
   qic_pair_t         stim;
   logic [QIC_DW-1:0] sample;
   logic              sample_valid;
   qic_pair_t         out_pair;
   logic              out_valid;
   logic              taken;
   logic              ovf;
   int                miscompares = 0;
   int                check_count = 0;
   int                cycles = 0;
   int                per;
   int                n;
   int                takes;

   qic_chain i_qic_chain (
      .I_SYS_CLK      (clk),
      .I_RST          (rst),
      .I_SAMPLE       (sample),
      .I_SAMPLE_VALID (sample_valid),
      .I_THIRD_SEL    (third),
      .I_QUARTER_FMT  (quart),
      .I_GAIN_BOOST   (boost),
      .I_CIC_RATE     (rate),
      .O_PAIR         (out_pair),
      .O_PAIR_VALID   (out_valid),
      .O_PAIR_TAKEN   (taken),
      .O_CIC_OVERFLOW (ovf)
   );

   qic_source i_qic_source (
      .i_clk    (clk),
      .i_rst    (rst),
      .i_en     (src_en),
      .i_halve  (halve),
      .i_taken  (taken),
      .i_pair   (stim),
      .o_sample (sample),
      .o_valid  (sample_valid)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ------
   // tasks
   // ------
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task do_reset(input int cnt);
      rst <= 1'b1;
      repeat (cnt) @(posedge clk);
      @(negedge clk);
      `QIC_CHECK("rst_pair", 24'h0, out_pair) // output cleared
      `QIC_CHECK("rst_taken", 1'b0, taken) // no pull in reset
      `QIC_CHECK("rst_ovf", 1'b0, ovf) // sticky flag cleared
      @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `QIC_CHECK("rst_valid", 1'b0, out_valid) // strobe low
      @(negedge clk);
      `QIC_CHECK("run_valid", 1'b1, out_valid) // strobe up
   endtask

   // cycles from here to the next pull pulse, capped
   task wait_taken(output int cnt);
      cnt = 1;
      @(negedge clk);
      while (taken !== 1'b1 && cnt < 2000) begin
         @(negedge clk);
         cnt++;
      end
   endtask

   // limit well above the ~31k cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 50000) begin
         miscompares++;
         finish_test();
      end
   end

   // ------
   // sequence
   // ------
   initial begin
      rst    = 1'b1;
      src_en = 1'b0;
      halve  = 1'b0;
      third  = 1'b0;
      quart  = 1'b0;
      boost  = 1'b0;
      rate   = 6'h02;
      stim   = 24'h0;
      do_reset(20);
      for (int k = 0; k < 9; k++) begin
         @(posedge clk);
         rate   <= ROWS[k].rate;
         third  <= ROWS[k].third;
         quart  <= ROWS[k].quart;
         boost  <= ROWS[k].boost;
         halve  <= ROWS[k].boost;
         stim   <= ROWS[k].stim;
         src_en <= 1'b1;
         do_reset(2);
         // rates 0 and 1 run as 2
         per = (ROWS[k].rate < 2) ? 2 : int'(ROWS[k].rate);
         per = per * ((ROWS[k].third | ROWS[k].quart) ? 8 : 4);
         repeat (64 * per) @(negedge clk);
         wait_taken(n);
         wait_taken(n);
         `QIC_CHECK("interval", per, n) // pull spacing
         repeat (2) begin
            @(negedge clk);
            `QIC_CHECK("pair", ROWS[k].want, out_pair) // dc
         end
         `QIC_CHECK("ovf", 1'b0, ovf) // no false overflow
      end
      // boost with unscaled data must overflow and stick
      @(posedge clk);
      rate  <= 6'h02;
      third <= 1'b0;
      quart <= 1'b0;
      boost <= 1'b1;
      halve <= 1'b0;
      stim  <= '{12'h600, 12'h100};
      do_reset(2);
      repeat (1000) @(negedge clk);
      `QIC_CHECK("ovf_set", 1'b1, ovf) // doubled out of range
      @(posedge clk);
      src_en <= 1'b0;
      repeat (1200) @(negedge clk);
      takes = 0;
      repeat (200) begin
         @(negedge clk);
         if (taken === 1'b1) begin
            takes++;
         end
      end
      `QIC_CHECK("starved_taken", 0, takes) // no pull pulse
      `QIC_CHECK("starved_pair", 24'h0, out_pair) // zeros flush
      `QIC_CHECK("ovf_held", 1'b1, ovf) // flag stays set
      @(posedge clk);
      do_reset(2); // only reset clears the flag
      finish_test();
   end

endmodule

`default_nettype wire
